/* rtl/hot_swap_reset_control.sv */
// Hot-swap reset, insertion notify, indicator and interrupt pin control
`timescale 1ns/1ns
`default_nettype none
`include "hot_swap_defines.svh"

// Notes on behaviour
// - Power-on reset low resets every internal resource, PLLs included.
// - Board-ok negated holds every internal resource in reset.
// - Ejector switch high means closed, board in operation mode.
// - Insertion-notify pulled low on fresh insertion or extraction.
// - Swap indicator low during reset, lamp control afterwards.
// - Secondary bus reset low resets secondary interface asynchronously.
module hot_swap_reset_control #(
   parameter int IRQ_PINS = `HS_IRQ_PINS,
   parameter int NOTIFY_CYC = `HS_NOTIFY_CYC
) (
   // System clock, reset and enable
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   // Reset pins
   input wire logic power_on_reset_n_i,
   input wire logic board_ok_n_i,
   input wire logic secondary_bus_reset_n_i,
   // Hot-swap pins
   input wire logic ejector_switch_i,
   output logic insert_notify_n_o,
   output logic insert_notify_oe_o,
   output logic swap_indicator_n_o,
   output logic swap_indicator_oe_o,
   // Lamp request from the core
   input wire logic lamp_on_i,
   // Interrupt pins, open drain
   input wire logic [IRQ_PINS-1:0] irq_pin_n_i,
   output logic [IRQ_PINS-1:0] irq_pin_n_o,
   output logic [IRQ_PINS-1:0] irq_pin_oe_o,
   input wire logic [IRQ_PINS-1:0] irq_assert_i,
   output logic [IRQ_PINS-1:0] irq_seen_o,
   // Reset outputs to the core
   output logic core_reset_n_o,
   output logic pll_reset_n_o,
   output logic pins_enable_o,
   output logic secondary_reset_n_o,
   output logic operation_mode_o
);
   import hot_swap_pkg::*;

   initial begin
      if (IRQ_PINS < 1 || IRQ_PINS > 32) $error("IRQ_PINS out of range");
      if (NOTIFY_CYC < 1 || NOTIFY_CYC > 4096) $error("NOTIFY_CYC bad");
   end

   // ===========================================================
   // Reset combination
   logic [1:0] rst_sync_q;
   wire sys_rst_n = rst_sync_q[1];
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // Any of the three causes (system reset, power-on reset, board-ok) asserts the chip reset at once
   wire chip_rst_n_raw = sys_rst_n & power_on_reset_n_i
                       & ~board_ok_n_i;
   logic [1:0] chip_rst_q;
   always_ff @(posedge clk_sys_i or negedge chip_rst_n_raw) begin
      if (!chip_rst_n_raw) chip_rst_q <= 2'h0;
      else chip_rst_q <= {chip_rst_q[0], 1'b1};
   end
   wire chip_rst_n = chip_rst_q[1];

   // Secondary interface reset, asynchronous assert
   wire sec_rst_n_raw = chip_rst_n_raw & secondary_bus_reset_n_i;
   logic [1:0] sec_rst_q;
   always_ff @(posedge clk_sys_i or negedge sec_rst_n_raw) begin
      if (!sec_rst_n_raw) sec_rst_q <= 2'h0;
      else sec_rst_q <= {sec_rst_q[0], 1'b1};
   end

   // ===========================================================
   // Pin input synchronisers
   logic ejector_s;
   logic [IRQ_PINS-1:0] irq_pin_s;
   sync_two_ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_ej (
      .clk_i(clk_sys_i),
      .rst_n_i(chip_rst_n),
      .en_i(clk_en_i),
      .d_i(ejector_switch_i),
      .q_o(ejector_s)
   );
   sync_two_ff #(.WIDTH(IRQ_PINS), .RESET_VAL({IRQ_PINS{1'b1}})) u_sync_irq (
      .clk_i(clk_sys_i),
      .rst_n_i(chip_rst_n),
      .en_i(clk_en_i),
      .d_i(irq_pin_n_i),
      .q_o(irq_pin_s)
   );

   // ===========================================================
   // Insertion and extraction sequencing
   swap_state_t state_q, state_d;
   logic [12:0] cnt_q, cnt_d;
   wire switch_closed = ejector_s;
   wire cnt_done = (cnt_q == 13'(NOTIFY_CYC - 1));

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_OFF: begin
            if (switch_closed) begin
               state_d = ST_INSERT;
               cnt_d = 13'h0;
            end
         end
         ST_INSERT: begin
            cnt_d = cnt_q + 13'h1;
            if (cnt_done) state_d = ST_RUN;
         end
         ST_RUN: begin
            if (!switch_closed) begin
               state_d = ST_EXTRACT;
               cnt_d = 13'h0;
            end
         end
         ST_EXTRACT: begin
            cnt_d = cnt_q + 13'h1;
            if (cnt_done) state_d = ST_OFF;
         end
         default: state_d = ST_OFF;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge chip_rst_n) begin
      if (!chip_rst_n) begin
         state_q <= ST_OFF;
         cnt_q <= 13'h0;
      end else if (clk_en_i) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   wire notify_d = (state_q == ST_INSERT) | (state_q == ST_EXTRACT);
   wire lamp_d = lamp_on_i | ~switch_closed;

   // ===========================================================
   // Registered pin drivers
   always_ff @(posedge clk_sys_i or negedge chip_rst_n) begin
      if (!chip_rst_n) begin
         insert_notify_oe_o <= 1'b0;
         swap_indicator_oe_o <= 1'b1;
         irq_pin_oe_o <= '0;
         irq_seen_o <= '0;
         operation_mode_o <= 1'b0;
      end else if (clk_en_i) begin
         insert_notify_oe_o <= notify_d;
         swap_indicator_oe_o <= lamp_d;
         irq_pin_oe_o <= irq_assert_i;
         irq_seen_o <= ~irq_pin_s;
         operation_mode_o <= switch_closed;
      end
   end

   // Open-drain data is always low; enables carry the level
   always_ff @(posedge clk_sys_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         insert_notify_n_o <= 1'b0;
         swap_indicator_n_o <= `HS_IND_RESET_LVL;
         irq_pin_n_o <= '0;
      end else begin
         insert_notify_n_o <= 1'b0;
         swap_indicator_n_o <= `HS_IND_RESET_LVL;
         irq_pin_n_o <= '0;
      end
   end

   // Reset outputs, released one clock after the chip reset
   always_ff @(posedge clk_sys_i or negedge chip_rst_n_raw) begin
      if (!chip_rst_n_raw) begin
         core_reset_n_o <= 1'b0;
         pll_reset_n_o <= 1'b0;
         pins_enable_o <= 1'b0;
      end else begin
         core_reset_n_o <= chip_rst_n;
         pll_reset_n_o <= chip_rst_n;
         pins_enable_o <= chip_rst_n;
      end
   end

   always_ff @(posedge clk_sys_i or negedge sec_rst_n_raw) begin
      if (!sec_rst_n_raw) secondary_reset_n_o <= 1'b0;
      else secondary_reset_n_o <= sec_rst_q[1];
   end
endmodule : hot_swap_reset_control
`default_nettype wire

/* rtl/hot_swap_defines.svh */
// Timing counts and reset values for the hot-swap reset control block
`ifndef HOT_SWAP_DEFINES_SVH
`define HOT_SWAP_DEFINES_SVH
// Number of general-purpose open-drain interrupt pins
`define HS_IRQ_PINS 6
// Indicator level driven while in reset (0 = pulled low)
`define HS_IND_RESET_LVL 1'b0
// Insertion-notify pulse length in ns, and cycles at 40 ns
`define HS_NOTIFY_NS 1000
`define HS_CLK_NS 40
`define HS_NOTIFY_CYC ((`HS_NOTIFY_NS + `HS_CLK_NS - 1) / `HS_CLK_NS)
`endif

/* rtl/hot_swap_pkg.sv */
// Types for the hot-swap reset control block
package hot_swap_pkg;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_INSERT = 2'b01,
      ST_RUN = 2'b10,
      ST_EXTRACT = 2'b11
   } swap_state_t;
endpackage : hot_swap_pkg

/* rtl/sync_two_ff.sv */
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least 1");
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RESET_VAL;
         q_o <= RESET_VAL;
      end else if (en_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : sync_two_ff
`default_nettype wire

/* sim/hot_swap_properties.sv */
// Checker for the hot-swap reset control block
`timescale 1ns/1ns
`default_nettype none
module hot_swap_properties #(parameter int NOTIFY_CYC = 2) (
   // Clock, reset and pin inputs
   input wire logic clk_sys_i, resetn_i, clk_en_i,
   input wire logic power_on_reset_n_i, board_ok_n_i,
   input wire logic secondary_bus_reset_n_i, ejector_switch_i,
   // Watched outputs
   input wire logic insert_notify_oe_o, swap_indicator_oe_o,
   input wire logic [5:0] irq_pin_oe_o,
   input wire logic core_reset_n_o, pll_reset_n_o, pins_enable_o,
   input wire logic secondary_reset_n_o, operation_mode_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic [7:0] hi_q;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) hi_q <= 8'h00;
      else hi_q <= insert_notify_oe_o ? hi_q + 8'h01 : 8'h00;
   end
   a_por_reset: assert property (
      !power_on_reset_n_i |-> !core_reset_n_o && !pll_reset_n_o)
      else $error("power-on reset not applied");
   a_board_reset: assert property (
      board_ok_n_i |-> !core_reset_n_o && !pll_reset_n_o)
      else $error("board-ok negated but not in reset");
   a_pins_released: assert property (
      !core_reset_n_o |-> !pins_enable_o && !insert_notify_oe_o
      && irq_pin_oe_o == 6'h00) else $error("pins driven in reset");
   a_switch_mode: assert property (
      pins_enable_o && $rose(ejector_switch_i) |-> ##[1:3] operation_mode_o)
      else $error("closed switch not seen");
   a_notify_len: assert property (
      $fell(insert_notify_oe_o) && core_reset_n_o |-> hi_q == 8'(NOTIFY_CYC))
      else $error("notify pulse length wrong");
   a_lamp_reset: assert property (
      !core_reset_n_o |-> swap_indicator_oe_o)
      else $error("lamp not low in reset");
   a_sec_reset: assert property (
      !secondary_bus_reset_n_i |-> !secondary_reset_n_o)
      else $error("secondary reset not forced");
   a_release_cause: assert property (
      $rose(core_reset_n_o) |-> $past(power_on_reset_n_i, 2)
      && !$past(board_ok_n_i, 2)) else $error("reset left too early");
   a_release_time: assert property (
      (power_on_reset_n_i && !board_ok_n_i && clk_en_i) [*5] |->
      core_reset_n_o && pll_reset_n_o) else $error("reset held too long");
   cover property ($rose(insert_notify_oe_o));
   cover property ($fell(secondary_bus_reset_n_i));
   cover property ($rose(core_reset_n_o));
endmodule : hot_swap_properties
bind hot_swap_reset_control hot_swap_properties
   #(.NOTIFY_CYC(NOTIFY_CYC)) u_props (.*);
`default_nettype wire

/* sim/hot_swap_backplane.sv */
// Backplane and system host model with pull-ups on open-drain lines
`timescale 1ns/1ns
`default_nettype none
module hot_swap_backplane (
   input wire logic clk_sys_i,
   input wire logic notify_oe_i,
   input wire logic [5:0] irq_oe_i,
   output logic power_on_reset_n_o, board_ok_n_o, ejector_switch_o,
   output logic notify_line_o,
   output logic [5:0] irq_line_o
);
   logic [5:0] ext_irq_q;
   initial begin
      power_on_reset_n_o = 1'b0;
      board_ok_n_o = 1'b1;
      ejector_switch_o = 1'b0;
      ext_irq_q = 6'h00;
   end
   assign notify_line_o = !notify_oe_i;
   assign irq_line_o = ~(irq_oe_i | ext_irq_q);
   task automatic apply(input logic por_n, ok_n, sw);
      @(negedge clk_sys_i);
      power_on_reset_n_o = por_n;
      ejector_switch_o = sw;
      // Board-ok only after power-on reset has settled
      if (!ok_n && board_ok_n_o) repeat (4) @(negedge clk_sys_i);
      board_ok_n_o = ok_n | !por_n;
   endtask : apply
endmodule : hot_swap_backplane
`default_nettype wire

/* sim/test_hot_swap_reset_control.sv */
// Testbench for the hot-swap reset control block
`timescale 1ns/1ns
`default_nettype none
module test_hot_swap_reset_control;
   logic clk_sys_i, resetn_i, clk_en_i, sec_n, lamp_on, por_n, ok_n, sw;
   logic n_oe, l_oe, core_n, pll_n, pins_en, sec_o, op_mode, n_line;
   logic [5:0] irq_line, irq_oe, irq_req, irq_seen, irq_dat;
   logic n_dat, l_dat;
   int errors = 0, total_checks = 0, cycles = 0, n;
   hot_swap_reset_control #(.IRQ_PINS(6), .NOTIFY_CYC(2)) dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
      .power_on_reset_n_i(por_n), .board_ok_n_i(ok_n),
      .secondary_bus_reset_n_i(sec_n), .ejector_switch_i(sw),
      .insert_notify_n_o(n_dat), .insert_notify_oe_o(n_oe),
      .swap_indicator_n_o(l_dat), .swap_indicator_oe_o(l_oe),
      .lamp_on_i(lamp_on), .irq_pin_n_i(irq_line), .irq_pin_n_o(irq_dat),
      .irq_pin_oe_o(irq_oe), .irq_assert_i(irq_req), .irq_seen_o(irq_seen),
      .core_reset_n_o(core_n), .pll_reset_n_o(pll_n),
      .pins_enable_o(pins_en), .secondary_reset_n_o(sec_o),
      .operation_mode_o(op_mode));
   hot_swap_backplane bp (.clk_sys_i(clk_sys_i), .notify_oe_i(n_oe),
      .irq_oe_i(irq_oe), .power_on_reset_n_o(por_n), .board_ok_n_o(ok_n),
      .ejector_switch_o(sw), .notify_line_o(n_line), .irq_line_o(irq_line));
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [5:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic pulse_len();
      n = 0;
      repeat (12) begin
         @(negedge clk_sys_i);
         if (n_line === 1'b0) n++;
      end
      chk("notify_len", 6'd2, 6'(n));
   endtask : pulse_len
   task automatic complete_run();
      if (errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      resetn_i = 1'b0;
      clk_en_i = 1'b1;
      sec_n = 1'b1;
      lamp_on = 1'b0;
      irq_req = 6'h3F;
      repeat (5) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      bp.apply(1'b1, 1'b1, 1'b1);
      bp.ext_irq_q = 6'h3F;
      repeat (8) @(negedge clk_sys_i);
      chk("core_held", 6'h00, {core_n, pll_n, pins_en, n_oe, op_mode});
      chk("lamp_held", 6'h01, l_oe);
      chk("irq_held", 6'h00, irq_oe);
      chk("irq_ignored", 6'h00, irq_seen);
      chk("pin_data", 6'h00, {n_dat, l_dat});
      chk("irq_data", 6'h00, irq_dat);
      bp.apply(1'b1, 1'b0, 1'b0);
      repeat (6) @(negedge clk_sys_i);
      chk("released", 6'h07, {core_n, pll_n, pins_en});
      chk("lamp_open", 6'h01, l_oe);
      irq_req = 6'h0A;
      bp.ext_irq_q = 6'h05;
      repeat (4) @(negedge clk_sys_i);
      chk("irq_oe", 6'h0A, irq_oe);
      chk("irq_seen", 6'h0F, irq_seen);
      bp.apply(1'b1, 1'b0, 1'b1);
      pulse_len();
      chk("mode_in", 6'h01, op_mode);
      chk("lamp_closed", 6'h00, l_oe);
      lamp_on = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      chk("lamp_req", 6'h01, l_oe);
      lamp_on = 1'b0;
      bp.apply(1'b1, 1'b0, 1'b0);
      pulse_len();
      chk("mode_out", 6'h00, op_mode);
      sec_n = 1'b0;
      #1 chk("sec_async", 6'h00, sec_o);
      @(negedge clk_sys_i);
      sec_n = 1'b1;
      bp.power_on_reset_n_o = 1'b0;
      #1 chk("por_async", 6'h00, {core_n, pll_n});
      @(negedge clk_sys_i);
      bp.power_on_reset_n_o = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      chk("por_release", 6'h07, {core_n, pll_n, sec_o});
      complete_run();
   end
endmodule : test_hot_swap_reset_control
`default_nettype wire
